// File: twi_pkg.sv
// package: constants and carrier types for the two-wire serial port mode
package twi_pkg;

	// shared control bit positions
	localparam int CTL_SOFTWARE_RESET_BIT_BIT  = 0;
	localparam int CTL_TWOWIRE_BIT = 5;
	localparam int CTL_SYNC_BIT   = 2;
	localparam int CTL_ENABLE_BIT = 0;
	localparam logic [7:0] SHARED_CTL_RESET = 8'h01;   // asynchronous uart, software reset set
	localparam logic [7:0] XFER_CTL_RESET   = 8'h00;
	localparam logic [7:0] XFER_CTL_KEEP    = 8'hF0;   // upper nibble survives disable

	// 10-bit address header pattern
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1E;

	// bus timing
	localparam int CLOCK_HZ        = 50_000_000;
	localparam int STD_RATE_BPS    = 100_000;
	localparam int FAST_RATE_BPS   = 400_000;
	localparam int STD_HALF_CYCLES  = CLOCK_HZ / (2 * STD_RATE_BPS);
	localparam int FAST_HALF_CYCLES = CLOCK_HZ / (2 * FAST_RATE_BPS);

	// master command from software
	typedef struct packed {
		logic       start;       // issue start or repeated start
		logic       stop;        // issue stop when idle between bytes
		logic       ten_bit;     // use 10-bit addressing
		logic       read;        // direction bit
		logic [9:0] target;      // slave address
	} master_cmd_t;

	// status back to software
	typedef struct packed {
		logic bus_busy_flag;
		logic arbitration_lost_flag;
		logic nack_seen;
		logic byte_done;
		logic addressed_as_slave;
		logic slave_read;
		logic master_active;
		logic hold_scl;
	} status_t;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_START = 7'b0000010,
		ST_BIT   = 7'b0000100,
		ST_ACK   = 7'b0001000,
		ST_WAIT  = 7'b0010000,
		ST_STOP  = 7'b0100000,
		ST_SLAVE = 7'b1000000
	} mstate_t;

endpackage : twi_pkg

// File: twowire_port.sv
// two-wire serial bus mode of the shared serial port: master, slave, control side effects
`timescale 1ns/1ps
// Function
// R1 - reset leaves uart mode; two-wire needs sync and two-wire bits both set
// R2 - software changes configuration only while enable is zero
// R3 - enable cleared stops traffic and releases both lines
// R4 - enable cleared clears transfer control bits 3-0, keeps 7-4
// R5 - enable cleared clears data control, data and shift registers
// R6 - enable cleared leaves control, count, timing, addresses, events alone
// R7 - software sets mode under soft reset, disables, configures, enables
// R8 - leaving two-wire: clear mode bits, set soft reset, then reinit
// R9 - master gives one clock pulse per data bit
// R10 - bytes shift out most significant bit first
// R11 - first byte is 7-bit address plus direction bit
// R12 - receiver drives acknowledge on ninth clock
// R13 - start is sda fall, stop is sda rise, with scl high
// R14 - busy flag sets on start, clears on stop
// R15 - sda changes only while scl low except start and stop; the slave role releases its ack on the ninth rising scl
// R16 - 10-bit header 11110, two high bits, direction, then low byte
// R17 - repeated start resends address with new direction
// R18 - standard 100 kbps and fast 400 kbps rates supported
// R19 - lost arbitration goes slave receiver and sets lost flag
// R20 - slave receiver acknowledges every byte; address byte acked here only on own address match
// R21 - scl held low after byte while processor action pending
// R22 - lines are open drain: pull low or release
// R23 - lines sampled on clock; start/stop from sampled sda edges
module twowire_port
	import twi_pkg::*;
(
	input  wire logic        clock,                  // 50 MHz peripheral clock
	input  wire logic        arst_n,                 // async reset, active low
	input  wire logic [7:0]  shared_serial_control,  // software control byte
	input  wire logic [7:0]  transfer_control_in,    // written transfer control value
	input  wire logic        transfer_control_wr,    // write strobe
	input  wire logic        fast_mode,              // 1 selects 400 kbps
	input  wire logic [6:0]  own_address_reg,        // own slave address
	input  wire master_cmd_t cmd,                    // master command fields
	input  wire logic        cmd_valid,              // command strobe
	input  wire logic [7:0]  tx_data,                // next byte to send
	input  wire logic        cpu_release,            // processor done, release scl
	input  wire logic        scl_in,                 // scl pin level
	input  wire logic        sda_in,                 // sda pin level
	output logic             scl_out,                // always low when driving
	output logic             scl_oe,                 // high while pulling scl low
	output logic             sda_out,                // always low when driving
	output logic             sda_oe,                 // high while pulling sda low
	output logic [7:0]       transfer_control_reg,   // transfer control readback
	output logic [7:0]       bus_data_reg,           // last received byte
	output status_t          status                  // status bits
);

	// ----------------------------------------------------------------
	// mode decode and line sampling
	// ----------------------------------------------------------------
	logic twowire_mode, twowire_module_enable;
	logic scl_q, sda_q, sda_prev;
	logic start_det, stop_det;
	// two-wire only when both mode bits set; reset default is uart (see R1)
	assign twowire_mode = shared_serial_control[CTL_SYNC_BIT] &
		shared_serial_control[CTL_TWOWIRE_BIT];
	assign twowire_module_enable = twowire_mode & shared_serial_control[CTL_ENABLE_BIT];

	// registered samples; pins are synchronous to clock (see R23)
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_q    <= scl_in;
			sda_q    <= sda_in;
			sda_prev <= sda_q;
		end
	end
	assign start_det = scl_q & sda_prev & ~sda_q;  // see R13, R23
	assign stop_det  = scl_q & ~sda_prev & sda_q;  // see R13, R23

	// ----------------------------------------------------------------
	// transfer control register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			transfer_control_reg <= XFER_CTL_RESET;
		else if (!twowire_module_enable)
			transfer_control_reg <= transfer_control_reg & XFER_CTL_KEEP;  // see R4
		else if (transfer_control_wr)
			transfer_control_reg <= transfer_control_in;  // see R2
	end

	// ----------------------------------------------------------------
	// bit engine
	// ----------------------------------------------------------------
	mstate_t    state_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [8:0] tick_cnt_reg;
	logic       phase_reg;         // 0: scl low half, 1: scl high half
	logic       is_master_reg, rw_reg, addr_phase_reg, second_addr_reg, ten_reg;
	logic [9:0] target_reg;
	logic       stop_pend_reg, busy_reg, al_reg, nack_reg, done_reg, hold_reg;
	logic       sda_drive, scl_drive, tick, mid;
	logic [8:0] half_cycles;

	// standard or fast half period (see R18)
	assign half_cycles = fast_mode ? 9'(FAST_HALF_CYCLES) : 9'(STD_HALF_CYCLES);
	assign tick = (tick_cnt_reg == half_cycles - 9'h001);
	// middle of a half period: sda moves here, well clear of any scl edge
	assign mid = (tick_cnt_reg == (half_cycles >> 1));

	// half period timer, runs in every state but idle and is held at zero while scl is held
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_reg <= 9'h000;
		else if (!twowire_module_enable || tick || state_reg == ST_IDLE || hold_reg)
			tick_cnt_reg <= 9'h000;
		else
			tick_cnt_reg <= tick_cnt_reg + 9'h001;
	end

	// bus busy tracking (see R14)
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			busy_reg <= 1'b0;
		else if (start_det)
			busy_reg <= 1'b1;
		else if (stop_det)
			busy_reg <= 1'b0;
	end

	// first address byte: 7-bit or 10-bit header (see R11, R16)
	function automatic logic [7:0] first_byte(input logic ten, input logic [9:0] a,
		input logic rd);
		first_byte = ten ? {TEN_BIT_HEADER, a[9:8], rd} : {a[6:0], rd};
	endfunction : first_byte

	// protocol sequencer for master and slave roles
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			phase_reg <= 1'b0;
			is_master_reg <= 1'b0;
			rw_reg <= 1'b0;
			addr_phase_reg <= 1'b0;
			second_addr_reg <= 1'b0;
			ten_reg <= 1'b0;
			target_reg <= 10'h000;
			stop_pend_reg <= 1'b0;
			al_reg <= 1'b0;
			nack_reg <= 1'b0;
			done_reg <= 1'b0;
			hold_reg <= 1'b0;
			bus_data_reg <= 8'h00;
			sda_drive <= 1'b0;
			scl_drive <= 1'b0;
		end else if (!twowire_module_enable) begin
			// stop, release lines, clear data and shifters; busy, lost, nack and done flags kept (see R3, R5, R6)
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bus_data_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			sda_drive <= 1'b0;
			scl_drive <= 1'b0;
			hold_reg <= 1'b0;
			is_master_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			// scl stays low until the next low half ends, so sda never moves under high scl
			if (hold_reg && cpu_release)
				hold_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (cmd_valid && cmd.start && !busy_reg) begin
						is_master_reg <= 1'b1;
						ten_reg <= cmd.ten_bit;
						target_reg <= cmd.target;
						rw_reg <= cmd.read;
						stop_pend_reg <= cmd.stop;
						al_reg <= 1'b0;
						nack_reg <= 1'b0;
						sda_drive <= 1'b1;           // sda falls while scl high (see R13)
						state_reg <= ST_START;
					end else if (start_det) begin
						state_reg <= ST_SLAVE;
						bit_cnt_reg <= 4'h0;
						addr_phase_reg <= 1'b1;
					end
				end
				ST_START: if (tick) begin
					if (scl_drive)
						scl_drive <= 1'b0;               // repeated start: free scl, sda high
					else if (!sda_drive)
						sda_drive <= 1'b1;               // sda falls while scl high (see R13)
					else begin
						scl_drive <= 1'b1;
						phase_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						addr_phase_reg <= 1'b1;
						second_addr_reg <= ten_reg & ~rw_reg;
						shift_reg <= first_byte(ten_reg, target_reg, rw_reg);
						state_reg <= ST_BIT;
					end
				end
				ST_BIT: begin
					// sda moves mid-way through scl low, msb first (see R10, R15)
					if (!phase_reg && mid)
						sda_drive <= (addr_phase_reg || !rw_reg) ? ~shift_reg[7] : 1'b0;
					if (tick && !phase_reg) begin
						scl_drive <= 1'b0;                // one pulse per bit (see R9)
						phase_reg <= 1'b1;
					end else if (tick) begin
						scl_drive <= 1'b1;
						phase_reg <= 1'b0;
						shift_reg <= {shift_reg[6:0], sda_q};
						if ((addr_phase_reg || !rw_reg) && !sda_drive && !sda_q) begin
							// lost to a lower value (see R19)
							al_reg <= 1'b1;
							is_master_reg <= 1'b0;
							scl_drive <= 1'b0;
							sda_drive <= 1'b0;
							state_reg <= ST_SLAVE;
						end else if (bit_cnt_reg == 4'h7)
							state_reg <= ST_ACK;
						else
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
				ST_ACK: begin
					// ninth clock: receiver drives ack, set mid-way through scl low (see R12)
					if (!phase_reg && mid)
						sda_drive <= (rw_reg && !addr_phase_reg);
					if (tick && !phase_reg) begin
						phase_reg <= 1'b1;
						scl_drive <= 1'b0;
					end else if (tick) begin
						scl_drive <= 1'b1;
						phase_reg <= 1'b0;
						if (!rw_reg || addr_phase_reg)
							nack_reg <= sda_q;
						if (rw_reg && !addr_phase_reg)
							bus_data_reg <= shift_reg;
						done_reg <= 1'b1;
						hold_reg <= 1'b1;               // wait for processor (see R21)
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: if (!hold_reg) begin
					bit_cnt_reg <= 4'h0;
					if (cmd_valid && cmd.start) begin
						// repeated start, address resent (see R17)
						rw_reg <= cmd.read;
						sda_drive <= 1'b0;               // sda freed while scl still low
						state_reg <= ST_START;
					end else if (stop_pend_reg || (cmd_valid && cmd.stop) || nack_reg) begin
						sda_drive <= 1'b1;
						state_reg <= ST_STOP;
					end else begin
						addr_phase_reg <= second_addr_reg;
						second_addr_reg <= 1'b0;
						shift_reg <= second_addr_reg ? target_reg[7:0] : tx_data;  // see R16
						state_reg <= ST_BIT;
					end
				end
				ST_STOP: if (tick) begin
					if (scl_drive)
						scl_drive <= 1'b0;
					else begin
						sda_drive <= 1'b0;               // sda rises with scl high (see R13)
						is_master_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				ST_SLAVE: begin
					// slave receiver: count bits on rising scl, ack data bytes, address byte only on own address match (see R20)
					if (stop_det)
						state_reg <= ST_IDLE;
					else if (scl_in && !scl_q) begin
						if (bit_cnt_reg == 4'h8) begin
							sda_drive <= 1'b0;
							bit_cnt_reg <= 4'h0;
							bus_data_reg <= shift_reg;
							done_reg <= 1'b1;
							addr_phase_reg <= 1'b0;
						end else begin
							shift_reg <= {shift_reg[6:0], sda_q};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end else if (!scl_in && scl_q && bit_cnt_reg == 4'h8)
						sda_drive <= !addr_phase_reg ||
							(shift_reg[7:1] == own_address_reg);
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// open-drain pins: only ever pull low (see R22)
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = scl_drive;
	assign sda_oe  = sda_drive;

	// status
	assign status = '{bus_busy_flag: busy_reg, arbitration_lost_flag: al_reg,
		nack_seen: nack_reg, byte_done: done_reg, addressed_as_slave: state_reg == ST_SLAVE,
		slave_read: rw_reg, master_active: is_master_reg, hold_scl: hold_reg};

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_release_on_disable;
		@(posedge clock) disable iff (!arst_n)
		!twowire_module_enable |=> !scl_oe && !sda_oe;
	endproperty
	a_release_on_disable: assert property (p_release_on_disable) // see R3
		else $error("lines not released after disable");

	property p_upper_nibble_kept;
		@(posedge clock) disable iff (!arst_n)
		!twowire_module_enable |=> transfer_control_reg[7:4] == $past(transfer_control_reg[7:4])
			&& transfer_control_reg[3:0] == 4'h0;
	endproperty
	a_upper_nibble_kept: assert property (p_upper_nibble_kept) // see R4
		else $error("transfer control disable effect wrong");

	property p_data_cleared;
		@(posedge clock) disable iff (!arst_n)
		!twowire_module_enable |=> bus_data_reg == 8'h00 && shift_reg == 8'h00;
	endproperty
	a_data_cleared: assert property (p_data_cleared) // see R5
		else $error("data not cleared on disable");

	property p_busy_on_start;
		@(posedge clock) disable iff (!arst_n)
		start_det |=> status.bus_busy_flag;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) // see R14
		else $error("busy not set after start");

	property p_idle_on_stop;
		@(posedge clock) disable iff (!arst_n)
		stop_det && !start_det |=> !status.bus_busy_flag;
	endproperty
	a_idle_on_stop: assert property (p_idle_on_stop) // see R14
		else $error("busy not cleared after stop");

	property p_sda_stable_high;
		@(posedge clock) disable iff (!arst_n)
		(state_reg == ST_BIT || state_reg == ST_ACK) && phase_reg && twowire_module_enable
			|=> $stable(sda_drive);
	endproperty
	a_sda_stable_high: assert property (p_sda_stable_high) // see R15
		else $error("sda moved during scl high");

	property p_arb_lost;
		@(posedge clock) disable iff (!arst_n)
		$rose(al_reg) |-> state_reg == ST_SLAVE && !is_master_reg;
	endproperty
	a_arb_lost: assert property (p_arb_lost) // see R19
		else $error("arbitration loss not handled");

	property p_hold_low;
		@(posedge clock) disable iff (!arst_n)
		hold_reg && !cpu_release && twowire_module_enable |=> scl_oe;
	endproperty
	a_hold_low: assert property (p_hold_low) // see R21
		else $error("scl not held during wait");

	property p_uart_default;
		@(posedge clock) disable iff (!arst_n)
		!twowire_mode |=> state_reg == ST_IDLE;
	endproperty
	a_uart_default: assert property (p_uart_default) // see R1
		else $error("engine active outside two-wire mode");

	c_master_start: cover property (@(posedge clock) disable iff (!arst_n)
		state_reg == ST_IDLE ##1 state_reg == ST_START);
	c_byte_done: cover property (@(posedge clock) disable iff (!arst_n) done_reg);
	c_arb_lost: cover property (@(posedge clock) disable iff (!arst_n) $rose(al_reg));
	c_slave: cover property (@(posedge clock) disable iff (!arst_n) state_reg == ST_SLAVE);

endmodule : twowire_port

// File: twi_slave_model.sv
// partner model: behavioural two-wire slave device standing on the bus
`timescale 1ns/1ps
module twi_slave_model (
	input  wire logic       clock,    // sampling clock
	input  wire logic       scl,      // resolved clock line
	input  wire logic       sda,      // resolved data line
	input  wire logic [7:0] rd_byte,  // byte returned on reads
	input  wire logic       refuse,   // 1 withholds the acknowledge
	input  wire logic       stretch,  // 1 holds scl low after each byte
	output logic            scl_oe,   // high while pulling scl low
	output logic            sda_oe,   // high while pulling sda low
	output logic [7:0]      rx_byte,  // last byte written by the master
	output logic [7:0]      rx_cnt    // bytes written since time zero
);
	logic       scl_q, sda_q, first, tx_mode, tx_next;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic [5:0] hold_cnt;

	// quiet bus at time zero
	initial begin
		{scl_q, sda_q, first, tx_mode, tx_next} = 5'h18;
		{bitn, sh, hold_cnt, scl_oe, sda_oe, rx_byte, rx_cnt} = '0;
	end

	// edges are judged on levels seen at rising clock edges, so glitches that fall between two clock edges are ignored
	always @(posedge clock) begin
		scl_q <= scl;
		sda_q <= sda;
		scl_oe <= (hold_cnt != 6'h00);
		if (hold_cnt != 6'h00)
			hold_cnt <= hold_cnt - 6'h01;
		if (scl && scl_q && sda_q && !sda) begin // start or repeated start
			bitn <= 4'h0;
			first <= 1'b1;
			tx_mode <= 1'b0;
			tx_next <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && scl_q && !sda_q && sda) begin // stop
			bitn <= 4'h0;
			first <= 1'b0;
			tx_mode <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && !scl_q) begin // one bit per pulse, msb first
			if (bitn < 4'h8)
				sh <= {sh[6:0], sda};
			if (bitn == 4'h7 && !tx_mode) begin
				rx_byte <= {sh[6:0], sda};
				rx_cnt <= rx_cnt + 8'h01;
				if (first)
					tx_next <= sda; // direction bit
				first <= 1'b0;
			end
			bitn <= bitn + 4'h1;
		end else if (!scl && scl_q) begin
			if (bitn == 4'h9) begin // byte over, optional stretch
				bitn <= 4'h0;
				tx_mode <= tx_next;
				hold_cnt <= stretch ? 6'h28 : 6'h00;
				sda_oe <= tx_next & ~rd_byte[7];
			end else if (tx_mode)
				sda_oe <= (bitn < 4'h8) && !rd_byte[3'(4'h7 - bitn)];
			else
				sda_oe <= (bitn == 4'h8) && !refuse; // acknowledge on ninth clock
		end
	end
endmodule : twi_slave_model

// File: twowire_port_tb.sv
// self-checking bench for the two-wire serial port mode
`timescale 1ns/1ps
module twowire_port_tb;
	import twi_pkg::*;
	logic        clock, arst_n, tctl_wr, fast_mode, cmd_valid, cpu_release;
	logic        refuse, stretch, scl_oe, sda_oe, scl_out, sda_out, m_scl_oe, m_sda_oe;
	logic [7:0]  ctl, tctl_in, tx_data, tctl, bdr, rd_byte, rx_byte, rx_cnt, w;
	logic [6:0]  own_addr, a;
	logic [9:0]  t;
	master_cmd_t cmd;
	status_t     status;
	int          fails, comparisons, cycles, hi_run, last_hi, seed;
	logic [7:0]  modes [4] = '{8'h01, 8'h05, 8'h21, 8'h24};
	wire         scl = !(scl_oe || m_scl_oe); // pull-up, open drain
	wire         sda = !(sda_oe || m_sda_oe); // pull-up, open drain

	twowire_port twowire_port_i (.clock(clock), .arst_n(arst_n), .shared_serial_control(ctl),
		.transfer_control_in(tctl_in), .transfer_control_wr(tctl_wr), .fast_mode(fast_mode),
		.own_address_reg(own_addr), .cmd(cmd), .cmd_valid(cmd_valid), .tx_data(tx_data),
		.cpu_release(cpu_release), .scl_in(scl), .sda_in(sda), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .transfer_control_reg(tctl),
		.bus_data_reg(bdr), .status(status));
	twi_slave_model twi_slave_model_i (.clock(clock), .scl(scl), .sda(sda), .rd_byte(rd_byte),
		.refuse(refuse), .stretch(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe),
		.rx_byte(rx_byte), .rx_cnt(rx_cnt));

	// ----------------------------------------
	// clock, timeout and high-time monitor
	// ----------------------------------------
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		hi_run <= scl ? hi_run + 1 : 0;
		if (!scl && hi_run != 0)
			last_hi <= hi_run;
		if (cycles == 90000) begin
			fails++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] addr_byte(input logic [6:0] ad, input logic rd);
		return {ad, rd};
	endfunction : addr_byte
	function automatic logic [7:0] hdr_byte(input logic [9:0] ad, input logic rd);
		return {5'h1E, ad[9:8], rd};
	endfunction : hdr_byte
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic go(input logic st, sp, tb, rd, input logic [9:0] tg, input logic rel);
		@(negedge clock);
		cmd = '{start: st, stop: sp, ten_bit: tb, read: rd, target: tg};
		cmd_valid = 1'b1;
		cpu_release = rel;
		@(negedge clock);
		// the engine acts on a command in the cycle after the release lands
		cmd_valid = rel;
		cpu_release = 1'b0;
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask : go
	// idle=0 waits for a byte hold, idle=1 for a free bus
	task automatic wait_for(input bit idle);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (n < 30000 && (idle ? status.bus_busy_flag !== 1'b0 : status.hold_scl !== 1'b1));
		check("wait bound", n < 30000, 1'b1);
	endtask : wait_for
	task automatic tc_write(input logic [7:0] v);
		@(negedge clock);
		tctl_in = v;
		tctl_wr = 1'b1;
		@(negedge clock);
		tctl_wr = 1'b0;
	endtask : tc_write
	task automatic set_ctl(input logic [7:0] v);
		@(negedge clock);
		ctl = v;
		repeat (2) @(negedge clock);
	endtask : set_ctl
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{clock, arst_n, tctl_wr, cmd_valid, cpu_release, refuse, stretch} = '0;
		{fails, comparisons, cycles, hi_run, last_hi} = '0;
		{tctl_in, tx_data, rd_byte} = '0;
		cmd = '0;
		fast_mode = 1'b1;
		ctl = SHARED_CTL_RESET;
		seed = $urandom(32'hBE26);
		own_addr = 7'($urandom);
		repeat (3) @(posedge clock);
		@(negedge clock);
		arst_n = 1'b1;
		check("tctl reset", tctl, XFER_CTL_RESET);
		// anything short of sync, two-wire and enable stays off the bus
		foreach (modes[i]) begin
			set_ctl(modes[i]);
			go(1'b1, 1'b0, 1'b0, 1'b0, 10'h055, 1'b0);
			repeat (300) @(negedge clock);
			check("silent mode", {scl_oe, sda_oe, status.bus_busy_flag}, 3'h0);
		end
		// disable keeps upper transfer control nibble only; writes refused meanwhile
		set_ctl(8'h25);
		w = 8'($urandom) | 8'h0F;
		tc_write(w);
		check("tctl write", tctl, w);
		set_ctl(8'h24);
		check("tctl disable", tctl, w & 8'hF0);
		tc_write(~w);
		check("tctl refused", tctl, w & 8'hF0);
		tc_write(8'h00);
		set_ctl(8'h25);
		// 7-bit write, then repeated start read
		a = 7'($urandom);
		tx_data = 8'($urandom);
		// the master acks every read byte, so the slave goes on sending; a set top bit
		// leaves sda free for the stop that follows
		rd_byte = 8'($urandom) | 8'h80;
		go(1'b1, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b0);
		while (sda === 1'b1 && cycles < 80000) @(negedge clock);
		check("start scl", scl, 1'b1);
		wait_for(1'b0);
		check("address byte", rx_byte, addr_byte(a, 1'b0));
		check("busy set", status.bus_busy_flag, 1'b1);
		check("fast high", last_hi >= FAST_HALF_CYCLES, 1'b1);
		go(1'b0, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b1);
		wait_for(1'b0);
		check("data byte", rx_byte, tx_data);
		check("acked", status.nack_seen, 1'b0);
		go(1'b1, 1'b0, 1'b0, 1'b1, {3'h0, a}, 1'b1);
		wait_for(1'b0);
		check("restart address", rx_byte, addr_byte(a, 1'b1));
		go(1'b0, 1'b0, 1'b0, 1'b1, {3'h0, a}, 1'b1);
		wait_for(1'b0);
		check("read byte", bdr, rd_byte);
		go(1'b0, 1'b1, 1'b0, 1'b1, {3'h0, a}, 1'b1);
		wait_for(1'b1);
		check("stop lines", {scl, sda, status.bus_busy_flag}, 3'h6);
		set_ctl(8'h24);
		check("data cleared", bdr, 8'h00);
		set_ctl(8'h25);
		// 10-bit write at standard rate against a stretching slave
		fast_mode = 1'b0;
		stretch = 1'b1;
		t = 10'($urandom);
		go(1'b1, 1'b0, 1'b1, 1'b0, t, 1'b0);
		wait_for(1'b0);
		check("ten header", rx_byte, hdr_byte(t, 1'b0));
		check("std high", last_hi >= STD_HALF_CYCLES, 1'b1);
		go(1'b0, 1'b0, 1'b1, 1'b0, t, 1'b1);
		wait_for(1'b0);
		check("ten low", rx_byte, t[7:0]);
		go(1'b0, 1'b1, 1'b1, 1'b0, t, 1'b1);
		wait_for(1'b1);
		fast_mode = 1'b1;
		stretch = 1'b0;
		// refused address ends in stop
		refuse = 1'b1;
		go(1'b1, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b0);
		wait_for(1'b0);
		check("nack seen", status.nack_seen, 1'b1);
		go(1'b0, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b1);
		wait_for(1'b1);
		refuse = 1'b0;
		// disable in mid-byte releases both lines at once
		go(1'b1, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b0);
		repeat (300) @(negedge clock);
		set_ctl(8'h24);
		check("lines released", {scl_oe, sda_oe}, 2'h0);
		// back to uart: clear the mode bits, then set soft reset
		set_ctl(8'h00);
		set_ctl(SHARED_CTL_RESET);
		go(1'b1, 1'b0, 1'b0, 1'b0, {3'h0, a}, 1'b0);
		repeat (300) @(negedge clock);
		check("uart again", {scl_oe, sda_oe, status.master_active}, 3'h0);
		tally_and_finish();
	end
endmodule : twowire_port_tb
